// ===== bench/hubb_host.sv
`timescale 1ns/1ps
module hubb_host (
  // clock
  input wire logic hclk,
  // frame setup
  input wire logic [1:0] par,
  input wire logic two_stop,
  input wire logic [15:0] div,
  input wire logic bad_par,
  // serial lines
  input wire logic txd,
  output logic rxd
);
  logic [7:0] got;
  logic got_perr;
  logic got_ferr;
  int frames;

  function automatic logic pbit(input logic [7:0] d);
    return (par == hubb_pkg::PAR_ODD) ? ~^d : ^d;
  endfunction

  task automatic drive(input logic b);
    rxd <= b;
    repeat (div) @(posedge hclk);
  endtask

  // bad_par flips the parity bit only when a scenario asks for it
  task automatic send_char(input logic [7:0] d);
    drive(1'b0);
    for (int i = 0; i < 8; i++) drive(d[i]);
    if (par != hubb_pkg::PAR_NONE) drive(pbit(d) ^ bad_par);
    drive(1'b1);
    if (two_stop) drive(1'b1);
  endtask

  task automatic send_low(input int n);
    rxd <= 1'b0;
    repeat (n) @(posedge hclk);
    rxd <= 1'b1;
  endtask

  initial begin
    rxd = 1'b1;
    frames = 0;
  end

  // receiver of the transmit line, sampling each bit at its centre
  initial forever begin
    @(negedge txd);
    repeat (div / 2) @(posedge hclk);
    got_ferr = (txd !== 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge hclk);
      got[i] = txd;
    end
    got_perr = 1'b0;
    if (par != hubb_pkg::PAR_NONE) begin
      repeat (div) @(posedge hclk);
      got_perr = (txd !== pbit(got));
    end
    repeat (div) @(posedge hclk);
    got_ferr = got_ferr | (txd !== 1'b1);
    if (two_stop) begin
      repeat (div) @(posedge hclk);
      got_ferr = got_ferr | (txd !== 1'b1);
    end
    frames++;
  end
endmodule

// ===== bench/hubb_uart_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s expected %0h seen %0h", n, e, g); end end
module hubb_uart_tb;
  typedef struct packed {logic [1:0] par; logic st2; logic bad; logic [7:0] d;} hubb_row_t;
  logic hclk, hresetn, hsel, hwrite, hrdy, hresp, irq, brq, dsl;
  logic rxd, cts_n, txd, txd_oe, rts_n, rts_oe, gtx, grts, grx, gcts, st2, bad;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, par;
  logic [2:0] hsize;
  logic [15:0] div;
  int miscompares, checks, pulses, lowc, pulse_at, n;
  hubb_row_t rows [4] = '{'{hubb_pkg::PAR_NONE, 1'b0, 1'b0, 8'h5A},
    '{hubb_pkg::PAR_ODD, 1'b0, 1'b0, 8'h3C}, '{hubb_pkg::PAR_EVEN, 1'b1, 1'b0, 8'hC3},
    '{hubb_pkg::PAR_ODD, 1'b1, 1'b1, 8'h81}};

  hubb_uart i_hubb_uart (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hrdy), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .irq(irq), .brk_reset_req(brq),
    .deep_sleep(dsl), .rxd(rxd), .clear_to_send_input_n(cts_n), .txd(txd),
    .txd_oe(txd_oe), .request_to_send_output_n(rts_n), .rts_oe(rts_oe),
    .gpio_txd_in(gtx), .gpio_rts_n_in(grts), .gpio_rxd_out(grx), .gpio_cts_n_out(gcts));
  hubb_host i_hubb_host (.hclk(hclk), .par(par), .two_stop(st2), .div(div),
    .bad_par(bad), .txd(txd), .rxd(rxd));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // length of the current low stretch on rxd and the break reset pulses seen
  always @(posedge hclk) begin
    lowc <= (rxd === 1'b0) ? lowc + 1 : 0;
    if (brq === 1'b1) begin
      pulses <= pulses + 1;
      pulse_at <= lowc;
    end
  end

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_frame();
    while (i_hubb_host.frames == n) @(posedge hclk);
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge hclk);
    miscompares++;
    finish_test();
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; cts_n = 1'b0; gtx = 1'b1; grts = 1'b1;
    par = 2'h0; st2 = 1'b0; bad = 1'b0; div = 16'h0008; pulses = 0; lowc = 0;
    repeat (12) @(posedge hclk);
    `CHK("txd_oe", 1'b0, txd_oe)
    `CHK("rts_oe", 1'b0, rts_oe)
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK("txd_oe", 1'b1, txd_oe)
    `CHK("txd", 1'b1, txd)
    `CHK("rts_oe", 1'b1, rts_oe)
    `CHK("hresp", 1'b0, hresp)
    bus(1'b0, hubb_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl", 32'h8, rd)
    bus(1'b0, hubb_pkg::ADDR_BRKTO, 32'h0);
    `CHK("brkto", 32'h0, rd)
    bus(1'b0, hubb_pkg::ADDR_BAUD, 32'h0);
    `CHK("baud", 32'(hubb_pkg::BAUD_DIV_RESET), rd)
    bus(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b1, hubb_pkg::ADDR_BAUD, 32'h2);
    bus(1'b0, hubb_pkg::ADDR_BAUD, 32'h0);
    `CHK("baud min", 32'h4, rd)
    bus(1'b1, hubb_pkg::ADDR_BAUD, 32'h8);
    foreach (rows[i]) begin
      par <= rows[i].par;
      st2 <= rows[i].st2;
      bad <= rows[i].bad;
      bus(1'b1, hubb_pkg::ADDR_CTRL, 32'({1'b1, rows[i].st2, rows[i].par}));
      n = i_hubb_host.frames;
      bus(1'b1, hubb_pkg::ADDR_TXDATA, 32'(rows[i].d));
      wait_frame();
      `CHK("tx byte", rows[i].d, i_hubb_host.got)
      `CHK("tx parity", 1'b0, i_hubb_host.got_perr)
      `CHK("tx stop", 1'b0, i_hubb_host.got_ferr)
      `CHK("rts_n", 1'b0, rts_n)
      i_hubb_host.send_char(~rows[i].d);
      repeat (4) @(posedge hclk);
      `CHK("rts_n", 1'b1, rts_n)
      bus(1'b0, hubb_pkg::ADDR_IRQ_STAT, 32'h0);
      `CHK("perr ev", rows[i].bad, rd[hubb_pkg::EV_PERR])
      `CHK("tx ev", 1'b1, rd[hubb_pkg::EV_TX])
      bus(1'b0, hubb_pkg::ADDR_RXDATA, 32'h0);
      if (!rows[i].bad) `CHK("rx byte", ~rows[i].d, rd[7:0])
      repeat (2) @(posedge hclk);
      `CHK("rts_n", 1'b0, rts_n)
    end
    bad <= 1'b0;
    bus(1'b1, hubb_pkg::ADDR_IRQ_MASK, 32'(1) << hubb_pkg::EV_RX);
    i_hubb_host.send_char(8'h42);
    repeat (4) @(posedge hclk);
    `CHK("irq", 1'b1, irq)
    bus(1'b0, hubb_pkg::ADDR_IRQ_STAT, 32'h0);
    repeat (3) @(posedge hclk);
    `CHK("irq", 1'b0, irq)
    bus(1'b0, hubb_pkg::ADDR_RXDATA, 32'h0);
    `CHK("rx byte", 8'h42, rd[7:0])
    bus(1'b1, hubb_pkg::ADDR_IRQ_MASK, 32'h0);
    // flow control holds a pending character until cts is asserted
    cts_n <= 1'b1;
    n = i_hubb_host.frames;
    bus(1'b1, hubb_pkg::ADDR_TXDATA, 32'hA5);
    repeat (150) @(posedge hclk);
    `CHK("held frames", n, i_hubb_host.frames)
    bus(1'b0, hubb_pkg::ADDR_STATE, 32'h0);
    `CHK("tx pend", 1'b1, rd[2])
    cts_n <= 1'b0;
    wait_frame();
    `CHK("tx byte", 8'hA5, i_hubb_host.got)
    bus(1'b1, hubb_pkg::ADDR_CTRL, 32'h18);
    repeat (4) @(posedge hclk);
    `CHK("break tx", 1'b0, txd)
    repeat (60) @(posedge hclk);
    `CHK("break tx", 1'b0, txd)
    bus(1'b1, hubb_pkg::ADDR_CTRL, 32'h08);
    repeat (120) @(posedge hclk);
    bus(1'b0, hubb_pkg::ADDR_IRQ_STAT, 32'h0);
    pulses = 0;
    i_hubb_host.send_low(120);
    repeat (20) @(posedge hclk);
    `CHK("pulses", 0, pulses)
    bus(1'b0, hubb_pkg::ADDR_IRQ_STAT, 32'h0);
    `CHK("break ev", 1'b1, rd[hubb_pkg::EV_BREAK])
    `CHK("rx ev", 1'b0, rd[hubb_pkg::EV_RX])
    bus(1'b1, hubb_pkg::ADDR_BRKTO, 32'd20);
    pulses = 0;
    i_hubb_host.send_low(120);
    repeat (20) @(posedge hclk);
    `CHK("pulses", 1, pulses)
    `CHK("pulse at", 1'b1, pulse_at inside {[21:24]})
    bus(1'b1, hubb_pkg::ADDR_CTRL, 32'h28);
    repeat (3) @(posedge hclk);
    `CHK("deep_sleep", 1'b1, dsl)
    gtx <= 1'b0;
    grts <= 1'b0;
    cts_n <= 1'b1;
    repeat (3) @(posedge hclk);
    `CHK("byp txd", 1'b0, txd)
    `CHK("byp rts_n", 1'b0, rts_n)
    `CHK("byp cts", 1'b1, gcts)
    fork
      i_hubb_host.send_low(6);
      begin repeat (4) @(posedge hclk); `CHK("byp rxd", 1'b0, grx) end
    join
    gtx <= 1'b1;
    cts_n <= 1'b0;
    bus(1'b1, hubb_pkg::ADDR_CTRL, 32'h0);
    repeat (3) @(posedge hclk);
    `CHK("deep_sleep", 1'b1, dsl)
    `CHK("byp txd", 1'b1, txd)
    `CHK("byp cts", 1'b0, gcts)
    hresetn <= 1'b0;
    par <= 2'h0;
    st2 <= 1'b0;
    repeat (3) @(posedge hclk);
    `CHK("txd_oe", 1'b0, txd_oe)
    `CHK("deep_sleep", 1'b0, dsl)
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    `CHK("gpio cts", 1'b1, gcts)
    // reset brought the divider back to its default; match the host model again
    bus(1'b1, hubb_pkg::ADDR_BAUD, 32'h8);
    i_hubb_host.send_char(8'h66);
    repeat (4) @(posedge hclk);
    bus(1'b0, hubb_pkg::ADDR_RXDATA, 32'h0);
    `CHK("rx byte", 8'h66, rd[7:0])
    // no flow control: cts is ignored and the character leaves at once
    bus(1'b1, hubb_pkg::ADDR_CTRL, 32'h0);
    cts_n <= 1'b1;
    n = i_hubb_host.frames;
    bus(1'b1, hubb_pkg::ADDR_TXDATA, 32'h3B);
    wait_frame();
    `CHK("tx byte", 8'h3B, i_hubb_host.got)
    finish_test();
  end
endmodule

// ===== hdl/hubb_pkg.sv
package hubb_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BAUD = 8'h04;
  localparam logic [7:0] ADDR_BRKTO = 8'h08;
  localparam logic [7:0] ADDR_TXDATA = 8'h0C;
  localparam logic [7:0] ADDR_RXDATA = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_STATE = 8'h1C;
  // control fields
  localparam int CTRL_PAR_LSB = 0;
  localparam int CTRL_STOP2 = 2;
  localparam int CTRL_FLOW = 3;
  localparam int CTRL_BREAK = 4;
  localparam int CTRL_BYPASS = 5;
  localparam logic [4:0] CTRL_RESET = 5'h08;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  // event bits
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_PERR = 2;
  localparam int EV_FERR = 3;
  localparam int EV_BREAK = 4;
  localparam int NUM_EV = 5;
  localparam int DATA_BITS = 8;
  localparam int FRAME_MAX = 12;
  localparam int CLK_HZ = 50000000;
  localparam int BAUD_DEFAULT = 115200;
  localparam logic [15:0] BAUD_DIV_RESET = 16'(CLK_HZ / BAUD_DEFAULT);
  localparam logic [15:0] BAUD_DIV_MIN = 16'h0004;
  localparam logic [31:0] BRKTO_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] parity;
    logic two_stop;
    logic [15:0] div;
  } hubb_cfg_t;

  typedef enum logic [1:0] {
    HUBB_IDLE = 2'b01,
    HUBB_BUSY = 2'b10
  } hubb_st_t;
endpackage

// ===== hdl/hubb_rx.sv
`timescale 1ns/1ps
module hubb_rx (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // line and setup
  input wire hubb_pkg::hubb_cfg_t cfg,
  input wire logic line,
  // character out
  output logic done,
  output logic [7:0] data,
  output logic perr,
  output logic ferr,
  output logic brk
);
  hubb_pkg::hubb_st_t st_q;
  logic [hubb_pkg::FRAME_MAX-1:0] sh_q;
  logic [3:0] left_q;
  logic [15:0] cnt_q;
  logic [3:0] nbits;
  logic bit_end;
  logic has_par;
  logic [7:0] dat;
  logic pbit;
  logic sbit;
  logic prev_q;

  assign has_par = (cfg.parity != hubb_pkg::PAR_NONE);
  // start, data, parity, first stop; second stop is not checked
  assign nbits = 4'd10 + 4'(has_par);
  // first sample half a bit in, then once per bit: centre of each bit
  assign bit_end = (cnt_q == 16'h0000);
  // at the stop sample the parity bit, if any, sits on top, data below it
  assign dat = has_par ? sh_q[hubb_pkg::FRAME_MAX-2 -: 8] : sh_q[hubb_pkg::FRAME_MAX-1 -: 8];
  assign pbit = sh_q[hubb_pkg::FRAME_MAX-1];
  // a high parity sample means the line was not held low throughout
  assign sbit = has_par && pbit;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= hubb_pkg::HUBB_IDLE;
      sh_q <= '0;
      left_q <= 4'h0;
      cnt_q <= 16'h0000;
      done <= 1'b0;
      data <= 8'h00;
      perr <= 1'b0;
      ferr <= 1'b0;
      brk <= 1'b0;
      prev_q <= 1'b1;
    end else begin
      done <= 1'b0;
      prev_q <= line;
      case (st_q)
        hubb_pkg::HUBB_IDLE: begin
          // only a falling edge starts a frame, so a held break is seen once
          if (prev_q && !line) begin
            cnt_q <= {1'b0, cfg.div[15:1]};
            left_q <= nbits;
            st_q <= hubb_pkg::HUBB_BUSY;
          end
        end
        hubb_pkg::HUBB_BUSY: begin
          cnt_q <= bit_end ? cfg.div - 16'h0001 : cnt_q - 16'h0001;
          if (bit_end) begin
            sh_q <= {line, sh_q[hubb_pkg::FRAME_MAX-1:1]};
            left_q <= left_q - 4'h1;
            if (left_q == 4'h1) begin
              st_q <= hubb_pkg::HUBB_IDLE;
              done <= 1'b1;
              data <= dat;
              perr <= has_par && ((^dat ^ pbit) != (cfg.parity == hubb_pkg::PAR_ODD));
              ferr <= !line;
              // all zero including stop: a break, not a character
              brk <= !line && (dat == 8'h00) && !sbit;
            end
          end
        end
        default: st_q <= hubb_pkg::HUBB_IDLE;
      endcase
    end
  end
endmodule

// ===== hdl/hubb_tx.sv
`timescale 1ns/1ps
module hubb_tx (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // character in
  input wire hubb_pkg::hubb_cfg_t cfg,
  input wire logic start,
  input wire logic [7:0] data,
  // status and line
  output logic busy,
  output logic done,
  output logic line
);
  hubb_pkg::hubb_st_t st_q;
  logic [hubb_pkg::FRAME_MAX-1:0] sh_q;
  logic [3:0] left_q;
  logic [15:0] cnt_q;
  logic par;
  logic [3:0] nbits;
  logic [hubb_pkg::FRAME_MAX-1:0] frame;
  logic bit_end;

  // start low, lsb first, optional parity, high stop bits
  assign par = ^data ^ (cfg.parity == hubb_pkg::PAR_ODD);
  assign nbits = 4'd10 + 4'(cfg.parity != hubb_pkg::PAR_NONE) + 4'(cfg.two_stop);
  assign frame = (cfg.parity == hubb_pkg::PAR_NONE) ?
                 {3'b111, data, 1'b0} : {2'b11, par, data, 1'b0};
  assign bit_end = (cnt_q == cfg.div - 16'h0001);
  assign busy = (st_q == hubb_pkg::HUBB_BUSY);
  assign line = busy ? sh_q[0] : 1'b1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= hubb_pkg::HUBB_IDLE;
      sh_q <= '1;
      left_q <= 4'h0;
      cnt_q <= 16'h0000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st_q)
        hubb_pkg::HUBB_IDLE: begin
          if (start) begin
            sh_q <= frame;
            left_q <= nbits;
            cnt_q <= 16'h0000;
            st_q <= hubb_pkg::HUBB_BUSY;
          end
        end
        hubb_pkg::HUBB_BUSY: begin
          cnt_q <= bit_end ? 16'h0000 : cnt_q + 16'h0001;
          if (bit_end) begin
            sh_q <= {1'b1, sh_q[hubb_pkg::FRAME_MAX-1:1]};
            left_q <= left_q - 4'h1;
            if (left_q == 4'h1) begin
              st_q <= hubb_pkg::HUBB_IDLE;
              done <= 1'b1;
            end
          end
        end
        default: st_q <= hubb_pkg::HUBB_IDLE;
      endcase
    end
  end
endmodule

// ===== hdl/hubb_uart.sv
`timescale 1ns/1ps
// Summary of operation
// - every character carries exactly eight data bits
// - parity none, odd or even; one or two stop bits; baud set by software
// - cts flow control is on after reset until software clears it; outside bypass rts follows the receive word
// - a break is the receive line held low, not a framed character
// - outside bypass, a low receive line longer than the timeout requests a device reset
// - timeout zero, the reset default, disables reset on break
// - software can hold the transmit line low to wake the host
// - all serial outputs are released while reset is held
// - after reset the host lines connect to the internal port
// - bypass command enters deep sleep at once; bypass routing stays active
// - only a physical reset leaves bypass
// - in bypass the host lines are routed to the general purpose pins
module hubb_uart (
  // ahb-lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // interrupt and system
  output logic irq,
  output logic brk_reset_req,
  output logic deep_sleep,
  // host serial lines
  input wire logic rxd,
  input wire logic clear_to_send_input_n,
  output logic txd,
  output logic txd_oe,
  output logic request_to_send_output_n,
  output logic rts_oe,
  // bypass pins
  input wire logic gpio_txd_in,
  input wire logic gpio_rts_n_in,
  output logic gpio_rxd_out,
  output logic gpio_cts_n_out
);
  logic [4:0] ctrl_q;
  logic [15:0] div_q;
  logic [31:0] brkto_q;
  logic [31:0] brk_cnt_q;
  logic [hubb_pkg::NUM_EV-1:0] stat_q;
  logic [hubb_pkg::NUM_EV-1:0] mask_q;
  logic [7:0] tx_hold_q;
  logic tx_pend_q;
  logic [7:0] rx_data_q;
  logic rx_full_q;
  logic bypass_q;
  logic dph_wr_q;
  logic [7:0] dph_addr_q;
  hubb_pkg::hubb_cfg_t cfg;
  logic tx_busy;
  logic tx_done;
  logic tx_line;
  logic tx_start;
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_perr;
  logic rx_ferr;
  logic rx_brk;
  logic aph;
  logic aph_rd;
  logic [7:0] aaddr;
  logic wr_en;
  logic cts_ok;
  logic brk_fire;
  logic [hubb_pkg::NUM_EV-1:0] ev;
  logic [31:0] rd_mux;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  // bus decode
  assign aph = hsel && htrans[1] && hready;
  assign aph_rd = aph && !hwrite;
  assign aaddr = haddr[7:0];
  assign wr_en = dph_wr_q;

  assign cfg.parity = ctrl_q[hubb_pkg::CTRL_PAR_LSB +: 2];
  assign cfg.two_stop = ctrl_q[hubb_pkg::CTRL_STOP2];
  assign cfg.div = div_q;

  // with flow control the transmitter waits for cts low
  assign cts_ok = !ctrl_q[hubb_pkg::CTRL_FLOW] || !clear_to_send_input_n;
  assign tx_start = tx_pend_q && !tx_busy && cts_ok && !ctrl_q[hubb_pkg::CTRL_BREAK]
                    && !bypass_q;

  // longer than the timeout: fires once on the cycle the count equals it
  assign brk_fire = (brkto_q != 32'h0000_0000) && !rxd && !bypass_q
                    && (brk_cnt_q == brkto_q);

  assign ev[hubb_pkg::EV_RX] = rx_done && !rx_brk;
  assign ev[hubb_pkg::EV_TX] = tx_done;
  assign ev[hubb_pkg::EV_PERR] = rx_done && rx_perr && !rx_brk;
  assign ev[hubb_pkg::EV_FERR] = rx_done && rx_ferr && !rx_brk;
  assign ev[hubb_pkg::EV_BREAK] = rx_done && rx_brk;

  assign rd_mux =
    hit(aaddr, hubb_pkg::ADDR_CTRL) ? {26'h0, bypass_q, ctrl_q} :
    hit(aaddr, hubb_pkg::ADDR_BAUD) ? {16'h0, div_q} :
    hit(aaddr, hubb_pkg::ADDR_BRKTO) ? brkto_q :
    hit(aaddr, hubb_pkg::ADDR_TXDATA) ? {24'h0, tx_hold_q} :
    hit(aaddr, hubb_pkg::ADDR_RXDATA) ? {24'h0, rx_data_q} :
    hit(aaddr, hubb_pkg::ADDR_IRQ_STAT) ? {27'h0, stat_q} :
    hit(aaddr, hubb_pkg::ADDR_IRQ_MASK) ? {27'h0, mask_q} :
    hit(aaddr, hubb_pkg::ADDR_STATE) ?
      {27'h0, deep_sleep, rx_full_q, tx_pend_q, tx_busy, clear_to_send_input_n} :
    32'h0000_0000;

  hubb_tx u_tx (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg(cfg),
    .start(tx_start),
    .data(tx_hold_q),
    .busy(tx_busy),
    .done(tx_done),
    .line(tx_line)
  );

  hubb_rx u_rx (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg(cfg),
    .line(rxd | bypass_q),
    .done(rx_done),
    .data(rx_data),
    .perr(rx_perr),
    .ferr(rx_ferr),
    .brk(rx_brk)
  );

  // bus phases; zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_q <= 1'b0;
      dph_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dph_wr_q <= aph && hwrite;
      if (aph) begin
        dph_addr_q <= aaddr;
      end
      if (aph_rd) begin
        hrdata <= rd_mux;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= hubb_pkg::CTRL_RESET;
      div_q <= hubb_pkg::BAUD_DIV_RESET;
      brkto_q <= hubb_pkg::BRKTO_RESET;
      mask_q <= '0;
    end else if (wr_en) begin
      if (hit(dph_addr_q, hubb_pkg::ADDR_CTRL)) begin
        ctrl_q <= hwdata[4:0];
      end
      if (hit(dph_addr_q, hubb_pkg::ADDR_BAUD)) begin
        div_q <= (hwdata[15:0] < hubb_pkg::BAUD_DIV_MIN) ?
                 hubb_pkg::BAUD_DIV_MIN : hwdata[15:0];
      end
      if (hit(dph_addr_q, hubb_pkg::ADDR_BRKTO)) begin
        brkto_q <= hwdata;
      end
      if (hit(dph_addr_q, hubb_pkg::ADDR_IRQ_MASK)) begin
        mask_q <= hwdata[hubb_pkg::NUM_EV-1:0];
      end
    end
  end

  // bypass latches until the asynchronous reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bypass_q <= 1'b0;
      deep_sleep <= 1'b0;
    end else begin
      if (wr_en && hit(dph_addr_q, hubb_pkg::ADDR_CTRL) && hwdata[hubb_pkg::CTRL_BYPASS]) begin
        bypass_q <= 1'b1;
      end
      deep_sleep <= deep_sleep || bypass_q ||
                    (wr_en && hit(dph_addr_q, hubb_pkg::ADDR_CTRL) &&
                     hwdata[hubb_pkg::CTRL_BYPASS]);
    end
  end

  // transmit holding word and receive word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_hold_q <= 8'h00;
      tx_pend_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_full_q <= 1'b0;
    end else begin
      if (wr_en && hit(dph_addr_q, hubb_pkg::ADDR_TXDATA) && !tx_pend_q) begin
        tx_hold_q <= hwdata[7:0];
        tx_pend_q <= 1'b1;
      end else if (tx_start) begin
        tx_pend_q <= 1'b0;
      end
      if (ev[hubb_pkg::EV_RX]) begin
        rx_data_q <= rx_data;
        rx_full_q <= 1'b1;
      end else if (aph_rd && hit(aaddr, hubb_pkg::ADDR_RXDATA)) begin
        rx_full_q <= 1'b0;
      end
    end
  end

  // sticky status: a new event wins over the clear by read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= '0;
      irq <= 1'b0;
    end else begin
      stat_q <= ((aph_rd && hit(aaddr, hubb_pkg::ADDR_IRQ_STAT)) ? '0 : stat_q) | ev;
      irq <= |(stat_q & mask_q);
    end
  end

  // break length counter and reset request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brk_cnt_q <= 32'h0000_0000;
      brk_reset_req <= 1'b0;
    end else begin
      if (rxd) begin
        brk_cnt_q <= 32'h0000_0000;
      end else if (brk_cnt_q != 32'hFFFF_FFFF) begin
        brk_cnt_q <= brk_cnt_q + 32'h0000_0001;
      end
      brk_reset_req <= brk_fire;
    end
  end

  // pins: released in reset, routed to gpio in bypass
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd <= 1'b1;
      txd_oe <= 1'b0;
      request_to_send_output_n <= 1'b1;
      rts_oe <= 1'b0;
      gpio_rxd_out <= 1'b1;
      gpio_cts_n_out <= 1'b1;
    end else begin
      txd_oe <= 1'b1;
      rts_oe <= 1'b1;
      if (bypass_q) begin
        txd <= gpio_txd_in;
        request_to_send_output_n <= gpio_rts_n_in;
        gpio_rxd_out <= rxd;
        gpio_cts_n_out <= clear_to_send_input_n;
      end else begin
        txd <= tx_line && !ctrl_q[hubb_pkg::CTRL_BREAK];
        request_to_send_output_n <= rx_full_q;
        gpio_rxd_out <= 1'b1;
        gpio_cts_n_out <= 1'b1;
      end
    end
  end

  // checks
  a_break_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    !bypass_q && ctrl_q[hubb_pkg::CTRL_BREAK] |=> !txd)
    else $error("break request did not hold txd low");
  a_bypass_stays: assert property (@(posedge hclk) disable iff (!hresetn)
    bypass_q |=> bypass_q && deep_sleep)
    else $error("bypass or sleep was left without reset");
  a_bypass_sleep: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(bypass_q) |-> deep_sleep)
    else $error("bypass did not enter deep sleep");
  a_bypass_route: assert property (@(posedge hclk) disable iff (!hresetn)
    bypass_q ##1 bypass_q |-> gpio_rxd_out == $past(rxd))
    else $error("host rx not routed to gpio");
  a_cts_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(tx_busy) |-> !$past(ctrl_q[hubb_pkg::CTRL_FLOW]) ||
    !$past(clear_to_send_input_n))
    else $error("transmit started without clear to send");
  a_brk_timeout: assert property (@(posedge hclk) disable iff (!hresetn)
    brk_reset_req |-> brkto_q != 32'h0000_0000 && $past(brk_cnt_q) == brkto_q)
    else $error("break reset at wrong count");
  a_brk_low: assert property (@(posedge hclk) disable iff (!hresetn)
    brk_reset_req |-> $past(!rxd, 1) && $past(!rxd, 2))
    else $error("break reset without low line");
  a_pins_out: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) ##1 1'b1 |-> txd_oe && rts_oe)
    else $error("serial pins not driven after reset");
  a_tx_frame: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_start && !ctrl_q[hubb_pkg::CTRL_BREAK] |=> !tx_line [*2])
    else $error("start bit missing");
  a_route_norm: assert property (@(posedge hclk) disable iff (!hresetn)
    !bypass_q && !ctrl_q[hubb_pkg::CTRL_BREAK] |=> txd == $past(tx_line))
    else $error("txd not from internal port");
  c_tx_char: cover property (@(posedge hclk) disable iff (!hresetn) tx_done);
  c_rx_char: cover property (@(posedge hclk) disable iff (!hresetn) ev[hubb_pkg::EV_RX]);
  c_brk_rst: cover property (@(posedge hclk) disable iff (!hresetn) brk_reset_req);
  c_bypass: cover property (@(posedge hclk) disable iff (!hresetn) $rose(bypass_q));
endmodule
